// *** common/psm_if.sv ***
interface psm_if;
  import psm_pkg::*;
  logic              busWr;
  logic              busRd;
  logic [ADDR_W-1:0] busAddr;
  logic [DATA_W-1:0] busWdata;
  logic [DATA_W-1:0] busRdata;
  logic              sysResetN;
  logic              wakeDevSink;
  logic              wakeDevPullUp;
  logic              wakeHostOut;
  logic              wakeHostOe;
  logic              wakeLevel;
  logic              relayDevOut;
  logic              relayDevOe;
  logic              relayHostOut;
  logic              relayHostOe;
  logic              relayLevel;

  // Wire levels of the two shared pins
  assign wakeLevel  = wakeHostOe ? wakeHostOut : ~wakeDevSink;
  assign relayLevel = relayDevOe ? relayDevOut :
                      (relayHostOe ? relayHostOut : 1'b1);

  modport dev (
    input  busWr, busRd, busAddr, busWdata, wakeLevel, relayLevel,
    output busRdata, sysResetN, wakeDevSink, wakeDevPullUp,
           relayDevOut, relayDevOe
  );
  modport host (
    input  busRdata, sysResetN, wakeLevel, relayLevel,
    output busWr, busRd, busAddr, busWdata, wakeHostOut, wakeHostOe,
           relayHostOut, relayHostOe
  );
endinterface

// *** common/psm_pkg.sv ***
package psm_pkg;
  // ***************************************************
  // Timing and widths
  // ***************************************************
  localparam int CLK_MHZ        = 50;
  localparam int WAKE_FILT_US   = 100;
  localparam int WAKE_FILT_CYC  = WAKE_FILT_US * CLK_MHZ;
  localparam int UV_DEGLITCH_US = 10;
  localparam int UV_DEGL_CYC    = UV_DEGLITCH_US * CLK_MHZ;
  localparam int LEADER_WAIT_US = 1000;
  localparam int LEADER_WAIT_CYC = LEADER_WAIT_US * CLK_MHZ;
  localparam int CNT_W          = 16;
  localparam int NUM_REG        = 4;
  localparam int ADDR_W         = 4;
  localparam int DATA_W         = 8;

  // ***************************************************
  // Device register map
  // ***************************************************
  localparam logic [3:0] STANDBY_CTRL_ADDR = 4'h0;
  localparam logic [3:0] HIB_CMD_ADDR      = 4'h1;
  localparam logic [3:0] HIB_STATE_ADDR    = 4'h2;
  localparam logic [3:0] PWR_MODE_ADDR     = 4'h3;
  localparam logic [3:0] WAKE_STATUS_ADDR  = 4'h4;
  localparam logic [7:0] LOW_POWER_CMD     = 8'h01;
  localparam int STANDBY_BIT = 0;

  // ***************************************************
  // Host register map
  // ***************************************************
  localparam logic [3:0] H_DEV_ADDR  = 4'h0;
  localparam logic [3:0] H_DEV_WDATA = 4'h1;
  localparam logic [3:0] H_DEV_RDCMD = 4'h2;
  localparam logic [3:0] H_DEV_RDATA = 4'h3;
  localparam logic [3:0] H_PIN_CTRL  = 4'h4;
  localparam logic [3:0] H_STATUS    = 4'h5;

  // Synchroniser bit positions in the device
  localparam int S_WAKE = 0;
  localparam int S_RELAY = 1;
  localparam int S_UVSUP = 2;
  localparam int S_UVINT = 3;
  localparam int S_UVCORE = 4;
  localparam int S_UVLIN = 5;
  localparam int S_POR = 6;
  localparam int S_FOLL = 7;
  localparam int S_LEAD = 8;
  localparam int SYNC_W = 9;

  typedef enum logic [2:0] {
    ST_CFG, ST_WAIT_EN, ST_RUN, ST_HIB, ST_LEAD_WAIT, ST_LOWPWR, ST_UVRST
  } pwr_state_t;
endpackage

// *** hdl/power_saving_ctrl.sv ***
// The register offsets and the plain strobed port are this design's own decisions.
module power_saving_ctrl
  import psm_pkg::*;
#(
  parameter logic [CNT_W-1:0] WAKE_FILT_CYCLES = CNT_W'(WAKE_FILT_CYC),
  parameter logic [CNT_W-1:0] UV_DEGL_CYCLES   = CNT_W'(UV_DEGL_CYC),
  parameter logic [CNT_W-1:0] LEADER_WAIT_CYCLES = CNT_W'(LEADER_WAIT_CYC)
) (
  input  wire logic               core_clk,       // System clock
  input  wire logic               rst,            // Sync reset
  psm_if.dev                      link,           // Host and pins
  input  wire logic               followerStrap,  // Follower config pin
  input  wire logic               leaderStrap,    // Leader config pin
  input  wire logic               uvSupply,       // Main supply UV
  input  wire logic               uvSupplyInt,    // Internal supply UV
  input  wire logic               uvCoreLdo,      // core_ldo_rail UV
  input  wire logic               uvLinMain,      // Linear regulator UV
  input  wire logic               porEvent,       // Power-on reset
  output logic [NUM_REG-1:0]      regEn,          // Regulator enables
  output logic                    chargePumpEn,   // Charge pump on
  output logic                    bridgeHiZ,      // Bridges off
  output logic                    coreClkEn,      // Internal clock run
  output logic                    coreLdoEn,      // core_ldo_rail on
  output logic                    lvSwitchOn,     // lv_switch_pin closed
  output logic                    linOutPulldown  // Linear output clamp
);
  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    pwr_state_t          st;
    logic [SYNC_W-1:0]   syncA;
    logic [SYNC_W-1:0]   syncB;
    logic                follower;
    logic                leader;
    logic                standby;
    logic [NUM_REG-1:0]  hibMask;
    logic                wakeEvt;
    logic                hibLatch;
    logic                wakePrev;
    logic                filtPrev;
    logic                filtLevel;
    logic                filtQual;
    logic [CNT_W-1:0]    filtCnt;
    logic [CNT_W-1:0]    uvCnt;
    logic                uvHit;
    logic [CNT_W-1:0]    waitCnt;
    logic                seenHigh;
    logic [DATA_W-1:0]   rdData;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;

  logic [SYNC_W-1:0] pinsIn;
  logic              wakeS;
  logic              relayS;
  logic              porS;
  logic              uvHibS;
  logic              qualLow;
  logic              qualHigh;
  logic              hibWake;
  logic              lpCmd;

  function automatic logic isWr(input logic [ADDR_W-1:0] a);
    isWr = link.busWr && (link.busAddr == a);
  endfunction

  function automatic logic isRd(input logic [ADDR_W-1:0] a);
    isRd = link.busRd && (link.busAddr == a);
  endfunction

  // Raw pins gathered for the synchroniser
  assign pinsIn = {leaderStrap, followerStrap, porEvent, uvLinMain,
                   uvCoreLdo, uvSupplyInt, uvSupply, link.relayLevel,
                   link.wakeLevel};
  assign wakeS    = s_r.syncB[S_WAKE];
  assign relayS   = s_r.syncB[S_RELAY];
  assign porS     = s_r.syncB[S_POR];
  assign uvHibS   = s_r.syncB[S_UVSUP] | s_r.syncB[S_UVINT] |
                    s_r.syncB[S_UVCORE];
  assign qualLow  = s_r.filtQual & ~s_r.filtLevel;
  assign qualHigh = s_r.filtQual & s_r.filtLevel;
  // Follower wakes from hibernate through the relay pin
  assign hibWake  = s_r.follower ? ~relayS : ~wakeS;
  assign lpCmd    = isWr(PWR_MODE_ADDR) &&
                    (link.busWdata == LOW_POWER_CMD);

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.syncA = pinsIn;
    s_nxt.syncB = s_r.syncA;
    s_nxt.wakePrev = wakeS;

    // Wake filter, restarts on any change
    if (wakeS != s_r.filtPrev) begin
      s_nxt.filtPrev = wakeS;
      s_nxt.filtCnt  = '0;
      s_nxt.filtQual = 1'b0;
    end else if (s_r.filtCnt >= WAKE_FILT_CYCLES - 1'b1) begin
      s_nxt.filtLevel = s_r.filtPrev;
      s_nxt.filtQual  = 1'b1;
    end else begin
      s_nxt.filtCnt = s_r.filtCnt + 1'b1;
    end

    // Linear regulator undervoltage deglitch
    s_nxt.uvHit = 1'b0;
    if (!s_r.syncB[S_UVLIN] || s_r.st != ST_RUN) begin
      s_nxt.uvCnt = '0;
    end else if (s_r.uvCnt >= UV_DEGL_CYCLES - 1'b1) begin
      s_nxt.uvHit = 1'b1;
    end else begin
      s_nxt.uvCnt = s_r.uvCnt + 1'b1;
    end

    // Wake pin seen high once after start-up
    if (s_r.st != ST_CFG && wakeS) begin
      s_nxt.seenHigh = 1'b1;
    end

    // Register writes
    if (isWr(STANDBY_CTRL_ADDR)) begin
      s_nxt.standby = link.busWdata[STANDBY_BIT];
    end

    // Flag clear on read, set wins
    if (isRd(WAKE_STATUS_ADDR) || isWr(WAKE_STATUS_ADDR)) begin
      s_nxt.wakeEvt = 1'b0;
    end
    if (isRd(HIB_STATE_ADDR) || isWr(HIB_STATE_ADDR)) begin
      s_nxt.hibLatch = 1'b0;
    end
    if (!s_r.follower && s_r.wakePrev && !wakeS) begin
      s_nxt.wakeEvt = 1'b1;
    end

    // Mode sequencing
    s_nxt.waitCnt = '0;
    case (s_r.st)
      ST_CFG: begin
        s_nxt.follower = s_r.syncB[S_FOLL];
        s_nxt.leader   = s_r.syncB[S_LEAD] & ~s_r.syncB[S_FOLL];
        s_nxt.seenHigh = 1'b0;
        s_nxt.st = s_r.syncB[S_FOLL] ? ST_WAIT_EN : ST_RUN;
      end
      ST_WAIT_EN: begin
        if (qualHigh) begin
          s_nxt.st = ST_RUN;
        end else if (qualLow) begin
          s_nxt.st = ST_LOWPWR;
        end
      end
      ST_RUN: begin
        if (s_r.uvHit) begin
          s_nxt.st = ST_UVRST;
        end else if (s_r.follower && qualLow) begin
          s_nxt.st = ST_LOWPWR;
        end else if (!s_r.follower && lpCmd) begin
          s_nxt.st = s_r.leader ? ST_LEAD_WAIT : ST_LOWPWR;
        end else if (isWr(HIB_CMD_ADDR)) begin
          s_nxt.hibMask = link.busWdata[NUM_REG-1:0];
          s_nxt.st = ST_HIB;
        end
      end
      ST_HIB: begin
        if (uvHibS) begin
          s_nxt.st = ST_RUN;
        end else if (hibWake) begin
          s_nxt.st = ST_RUN;
          s_nxt.hibLatch = 1'b1;
        end
      end
      ST_LEAD_WAIT: begin
        s_nxt.waitCnt = s_r.waitCnt + 1'b1;
        if (s_r.waitCnt >= LEADER_WAIT_CYCLES - 1'b1) begin
          s_nxt.st = ST_LOWPWR;
        end
      end
      ST_LOWPWR: begin
        if (s_r.follower ? qualHigh : qualLow) begin
          s_nxt.st = ST_CFG;
        end
      end
      ST_UVRST: begin
        if (!s_r.syncB[S_UVLIN]) begin
          s_nxt.st = ST_CFG;
        end
      end
      default: begin
        s_nxt.st = ST_CFG;
      end
    endcase

    // Standby ends on reset event or low power
    if (s_nxt.st == ST_LOWPWR || s_nxt.st == ST_UVRST) begin
      s_nxt.standby = 1'b0;
    end

    // POR restarts and clears latched flags
    if (porS) begin
      s_nxt.st       = ST_CFG;
      s_nxt.standby  = 1'b0;
      s_nxt.wakeEvt  = 1'b0;
      s_nxt.hibLatch = 1'b0;
    end

    // Read data, one cycle after strobe
    s_nxt.rdData = '0;
    if (link.busRd) begin
      case (link.busAddr)
        STANDBY_CTRL_ADDR: s_nxt.rdData = {7'h00, s_r.standby};
        HIB_CMD_ADDR:      s_nxt.rdData = {4'h0, s_r.hibMask};
        HIB_STATE_ADDR:    s_nxt.rdData = {6'h00, s_r.st == ST_HIB,
                                           s_r.hibLatch};
        PWR_MODE_ADDR:     s_nxt.rdData = {5'h00, s_r.st};
        WAKE_STATUS_ADDR:  s_nxt.rdData = {5'h00, s_r.leader,
                                           s_r.follower, s_r.wakeEvt};
        default:           s_nxt.rdData = '0;
      endcase
    end
  end

  // State register, synchroniser keeps running so straps are valid at release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.syncA <= pinsIn;
      s_r.syncB <= s_r.syncA;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign link.busRdata = s_r.rdData;
  // Reset output high in run and leader wait, low otherwise
  assign link.sysResetN = (s_r.st == ST_RUN) ||
                          (s_r.st == ST_LEAD_WAIT);
  // Sink until config known, then per mode
  assign link.wakeDevSink = (s_r.st == ST_CFG) ||
                            (s_r.follower && !s_r.seenHigh);
  assign link.wakeDevPullUp = (s_r.st != ST_CFG) &&
                              !s_r.follower;
  // Leader relay low outside normal run
  assign link.relayDevOe  = s_r.leader;
  assign link.relayDevOut = (s_r.st == ST_RUN);

  // Regulators per mode
  always_comb begin
    case (s_r.st)
      ST_RUN, ST_LEAD_WAIT, ST_UVRST: regEn = '1;
      ST_HIB:  regEn = s_r.hibMask;
      default: regEn = '0;
    endcase
  end

  assign chargePumpEn   = (s_r.st == ST_RUN) || (s_r.st == ST_HIB) ||
                          (s_r.st == ST_LEAD_WAIT) ||
                          (s_r.st == ST_UVRST);
  assign bridgeHiZ      = (s_r.st != ST_RUN);
  assign coreClkEn      = (s_r.st != ST_LOWPWR);
  assign coreLdoEn      = !s_r.standby;
  assign lvSwitchOn     = s_r.standby;
  assign linOutPulldown = !regEn[0];
endmodule // power_saving_ctrl

// *** hdl/psm_host_end.sv ***
module psm_host_end
  import psm_pkg::*;
(
  input  wire logic              core_clk, // System clock
  input  wire logic              rst,      // Sync reset
  psm_if.host                    link,     // Device side
  input  wire logic [ADDR_W-1:0] addr,     // Register address
  input  wire logic [DATA_W-1:0] wdata,    // Write data
  input  wire logic              wr,       // Write strobe
  input  wire logic              rd,       // Read strobe
  output logic [DATA_W-1:0]      rdata     // Read data, next cycle
);
  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] devAddr;
    logic [DATA_W-1:0] devWdata;
    logic [3:0]        pinCtrl;
    logic              issueWr;
    logic              issueRd;
    logic              capNext;
    logic              rdDone;
    logic [DATA_W-1:0] devRdata;
    logic [2:0]        sA;
    logic [2:0]        sB;
    logic [DATA_W-1:0] rdData;
  } host_state_t;

  host_state_t h_r;
  host_state_t h_nxt;

  // Next state
  always_comb begin
    h_nxt = h_r;
    h_nxt.sA = {link.relayLevel, link.wakeLevel, link.sysResetN};
    h_nxt.sB = h_r.sA;
    h_nxt.issueWr = 1'b0;
    h_nxt.issueRd = 1'b0;
    h_nxt.capNext = h_r.issueRd;
    if (h_r.capNext) begin
      h_nxt.devRdata = link.busRdata;
      h_nxt.rdDone = 1'b1;
    end
    if (wr) begin
      case (addr)
        H_DEV_ADDR:  h_nxt.devAddr = wdata[ADDR_W-1:0];
        H_DEV_WDATA: begin
          h_nxt.devWdata = wdata;
          h_nxt.issueWr = 1'b1;
        end
        H_DEV_RDCMD: begin
          h_nxt.issueRd = 1'b1;
          h_nxt.rdDone = 1'b0;
        end
        H_PIN_CTRL:  h_nxt.pinCtrl = wdata[3:0];
        default: ;
      endcase
    end
    h_nxt.rdData = '0;
    if (rd) begin
      case (addr)
        H_DEV_ADDR:  h_nxt.rdData = {4'h0, h_r.devAddr};
        H_DEV_WDATA: h_nxt.rdData = h_r.devWdata;
        H_DEV_RDATA: h_nxt.rdData = h_r.devRdata;
        H_PIN_CTRL:  h_nxt.rdData = {4'h0, h_r.pinCtrl};
        H_STATUS:    h_nxt.rdData = {4'h0, h_r.rdDone, h_r.sB};
        default:     h_nxt.rdData = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign rdata         = h_r.rdData;
  assign link.busWr    = h_r.issueWr;
  assign link.busRd    = h_r.issueRd;
  assign link.busAddr  = h_r.devAddr;
  assign link.busWdata = h_r.devWdata;
  // Wake and relay drive for external wake
  assign link.wakeHostOe   = h_r.pinCtrl[0];
  assign link.wakeHostOut  = h_r.pinCtrl[1];
  assign link.relayHostOe  = h_r.pinCtrl[2];
  assign link.relayHostOut = h_r.pinCtrl[3];
endmodule // psm_host_end

// *** verif/psm_asserts.sv ***
module psm_asserts
  import psm_pkg::*;
(
  input wire logic              core_clk,      // Clock
  input wire logic              rst,           // Sync reset
  input wire logic              busWr,         // Device write strobe
  input wire logic              busRd,         // Device read strobe
  input wire logic [ADDR_W-1:0] busAddr,       // Device address
  input wire logic [DATA_W-1:0] busWdata,      // Device write data
  input wire logic [DATA_W-1:0] busRdata,      // Device read data
  input wire logic              sysResetN,     // Reset output
  input wire logic              wakeDevSink,   // Wake sink on
  input wire logic              wakeDevPullUp, // Wake pull-up on
  input wire logic              wakeLevel,     // Wake wire level
  input wire logic              relayDevOe,    // Relay drive on
  input wire logic              relayDevOut    // Relay drive value
);
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************
  // Checks on the link
  // ***************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Accepted low power command from a running non-follower
  logic lpWr;
  assign lpWr = busWr && busAddr == PWR_MODE_ADDR &&
                busWdata == LOW_POWER_CMD && sysResetN && wakeDevPullUp;

  property p_rdata_idle;
    !$past(busRd) |-> busRdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its answer cycle");

  property p_one_strobe;
    !(busWr && busRd);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("write and read strobe together");

  property p_reset_sink;
    $past(rst) |-> wakeDevSink && !sysResetN;
  endproperty
  a_reset_sink: assert property (p_reset_sink)
    else $error("wake sink off or reset released at start-up");

  property p_sink_vs_pullup;
    wakeDevSink |-> !wakeDevPullUp;
  endproperty
  a_sink_vs_pullup: assert property (p_sink_vs_pullup)
    else $error("wake sink and pull-up on together");

  property p_sink_release;
    wakeLevel [*8] ##0 sysResetN |-> !wakeDevSink;
  endproperty
  a_sink_release: assert property (p_sink_release)
    else $error("wake sink kept on with wake high");

  property p_hib_entry;
    busWr && busAddr == HIB_CMD_ADDR && sysResetN &&
      !(relayDevOe && !relayDevOut) |=> !sysResetN;
  endproperty
  a_hib_entry: assert property (p_hib_entry)
    else $error("hibernate write left reset output high");

  property p_lp_entry;
    lpWr && !relayDevOe |=> !sysResetN && wakeDevPullUp;
  endproperty
  a_lp_entry: assert property (p_lp_entry)
    else $error("low power entry without reset low and pull-up");

  property p_leader_relay;
    lpWr && relayDevOe && relayDevOut |=>
      (relayDevOe && !relayDevOut) [*8];
  endproperty
  a_leader_relay: assert property (p_leader_relay)
    else $error("relay not held low after leader low power write");
endmodule // psm_asserts

// *** verif/tb_power_saving_mode_control.sv ***
module tb_power_saving_mode_control
  import psm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0] wa;
    logic [7:0] wd;
    logic [3:0] ra;
    logic [7:0] rexp;
    logic       lv;
    logic       ldo;
  } row_t;

  // ***************************************************
  // Signals and instances
  // ***************************************************
  logic         core_clk  = 1'b0;
  logic         rst       = 1'b1;
  logic [3:0]   addr      = 4'h0;
  logic [7:0]   wdata     = 8'h00;
  logic         wr        = 1'b0;
  logic         rd        = 1'b0;
  logic         folStrap  = 1'b0;
  logic         leadStrap = 1'b0;
  logic         uvS       = 1'b0;
  logic         uvI       = 1'b0;
  logic         uvC       = 1'b0;
  logic         uvL       = 1'b0;
  logic         por       = 1'b0;
  logic [7:0]   rdata;
  logic [7:0]   v;
  logic [3:0]   regEn;
  logic         cpEn, hiZ, clkEn, ldoEn, lvSw, linPd;
  int           errorCnt  = 0;
  int           cmpCount  = 0;
  int           cyc       = 0;
  row_t         rows [4]  = '{
    '{4'h0, 8'h01, 4'h0, 8'h01, 1'b1, 1'b0},
    '{4'h0, 8'h00, 4'h0, 8'h00, 1'b0, 1'b1},
    '{4'hf, 8'hff, 4'hf, 8'h00, 1'b0, 1'b1},
    '{4'h3, 8'h02, 4'h3, 8'h02, 1'b0, 1'b1}
  };

  psm_if link ();

  power_saving_ctrl #(
    .WAKE_FILT_CYCLES  (16'h0008),
    .UV_DEGL_CYCLES    (16'h0004),
    .LEADER_WAIT_CYCLES(16'h0010)
  ) power_saving_ctrl_i (
    .core_clk(core_clk), .rst(rst), .link(link),
    .followerStrap(folStrap), .leaderStrap(leadStrap),
    .uvSupply(uvS), .uvSupplyInt(uvI), .uvCoreLdo(uvC),
    .uvLinMain(uvL), .porEvent(por), .regEn(regEn),
    .chargePumpEn(cpEn), .bridgeHiZ(hiZ), .coreClkEn(clkEn),
    .coreLdoEn(ldoEn), .lvSwitchOn(lvSw), .linOutPulldown(linPd)
  );

  psm_host_end psm_host_end_i (
    .core_clk(core_clk), .rst(rst), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  psm_asserts psm_asserts_i (
    .core_clk(core_clk), .rst(rst), .busWr(link.busWr),
    .busRd(link.busRd), .busAddr(link.busAddr),
    .busWdata(link.busWdata), .busRdata(link.busRdata),
    .sysResetN(link.sysResetN), .wakeDevSink(link.wakeDevSink),
    .wakeDevPullUp(link.wakeDevPullUp), .wakeLevel(link.wakeLevel),
    .relayDevOe(link.relayDevOe), .relayDevOut(link.relayDevOut)
  );

  // Clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errorCnt++;
      tally_and_finish();
    end
  end

  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic hwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic hrd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask

  task automatic dwr(input logic [3:0] a, input logic [7:0] d);
    hwr(H_DEV_ADDR, {4'h0, a});
    hwr(H_DEV_WDATA, d);
  endtask

  task automatic drd(input logic [3:0] a, output logic [7:0] d);
    hwr(H_DEV_ADDR, {4'h0, a});
    hwr(H_DEV_RDCMD, 8'h00);
    repeat (3) @(posedge core_clk);
    hrd(H_DEV_RDATA, d);
  endtask

  // Device register read compared with its expected value
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    drd(a, v);
    chk("devReg", v, e);
  endtask

  // Bounded wait for a level of the reset output
  task automatic wait_rn(input logic lvl);
    for (int i = 0; i < 300 && link.sysResetN !== lvl; i++)
      @(negedge core_clk);
    chk("sysResetN", link.sysResetN, {7'h00, lvl});
  endtask

  task automatic do_reset(input logic f, input logic l);
    @(posedge core_clk);
    rst <= 1'b1;
    folStrap <= f;
    leadStrap <= l;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic tally_and_finish;
    if (errorCnt == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    do_reset(1'b0, 1'b0);
    chk("sink", link.wakeDevSink, 1'b1);
    chk("linPd", linPd, 1'b1);
    wait_rn(1'b1);
    chk("pullUp", link.wakeDevPullUp, 1'b1);
    chk("sink", link.wakeDevSink, 1'b0);
    foreach (rows[k]) begin
      dwr(rows[k].wa, rows[k].wd);
      drd(rows[k].ra, v);
      chk("rowRd", v, rows[k].rexp);
      chk("lvSw", lvSw, rows[k].lv);
      chk("ldo", ldoEn, rows[k].ldo);
    end
    // Hibernate left by the wake pin, then latch read and cleared
    dwr(HIB_CMD_ADDR, 8'h05);
    settle(2);
    chk("regEn", regEn, 4'h5);
    rdchk(HIB_STATE_ADDR, 8'h02);
    hwr(H_PIN_CTRL, 8'h01);
    wait_rn(1'b1);
    hwr(H_PIN_CTRL, 8'h00);
    rdchk(HIB_STATE_ADDR, 8'h01);
    rdchk(HIB_STATE_ADDR, 8'h00);
    rdchk(WAKE_STATUS_ADDR, 8'h01);
    rdchk(WAKE_STATUS_ADDR, 8'h00);
    // Hibernate left by undervoltage, no latch
    dwr(HIB_CMD_ADDR, 8'h00);
    settle(2);
    chk("regEn", regEn, 4'h0);
    @(posedge core_clk) uvC <= 1'b1;
    repeat (6) @(posedge core_clk);
    uvC <= 1'b0;
    wait_rn(1'b1);
    rdchk(HIB_STATE_ADDR, 8'h00);
    // Linear undervoltage: short glitch ignored, long one resets
    dwr(STANDBY_CTRL_ADDR, 8'h01);
    @(posedge core_clk) uvL <= 1'b1;
    repeat (2) @(posedge core_clk);
    uvL <= 1'b0;
    rdchk(PWR_MODE_ADDR, 8'h02);
    @(posedge core_clk) uvL <= 1'b1;
    wait_rn(1'b0);
    rdchk(PWR_MODE_ADDR, 8'h06);
    chk("hiZ", hiZ, 1'b1);
    @(posedge core_clk) uvL <= 1'b0;
    wait_rn(1'b1);
    rdchk(STANDBY_CTRL_ADDR, 8'h00);
    // Low power by command, short wake ignored, long wake exits
    dwr(STANDBY_CTRL_ADDR, 8'h01);
    dwr(PWR_MODE_ADDR, LOW_POWER_CMD);
    settle(2);
    chk("hiZ", hiZ, 1'b1);
    chk("regEn", regEn, 4'h0);
    chk("cpEn", cpEn, 1'b0);
    chk("clkEn", clkEn, 1'b0);
    chk("pullUp", link.wakeDevPullUp, 1'b1);
    chk("sysResetN", link.sysResetN, 1'b0);
    chk("ldo", ldoEn, 1'b1);
    chk("linPd", linPd, 1'b1);
    hwr(H_PIN_CTRL, 8'h01);
    repeat (3) @(posedge core_clk);
    hwr(H_PIN_CTRL, 8'h00);
    settle(20);
    chk("clkEn", clkEn, 1'b0);
    hwr(H_PIN_CTRL, 8'h01);
    repeat (20) @(posedge core_clk);
    hwr(H_PIN_CTRL, 8'h00);
    wait_rn(1'b1);
    rdchk(STANDBY_CTRL_ADDR, 8'h00);
    // Power-on event leaves low power and clears the wake flag
    dwr(PWR_MODE_ADDR, LOW_POWER_CMD);
    @(posedge core_clk) por <= 1'b1;
    repeat (4) @(posedge core_clk);
    por <= 1'b0;
    wait_rn(1'b1);
    rdchk(WAKE_STATUS_ADDR, 8'h00);
    // Leader: relay low at once, low power after the wait
    do_reset(1'b0, 1'b1);
    wait_rn(1'b1);
    dwr(PWR_MODE_ADDR, LOW_POWER_CMD);
    settle(2);
    chk("relay", link.relayLevel, 1'b0);
    chk("clkEn", clkEn, 1'b1);
    settle(24);
    chk("clkEn", clkEn, 1'b0);
    // Follower: wake pin as enable, relay ends hibernate
    do_reset(1'b1, 1'b0);
    settle(24);
    chk("clkEn", clkEn, 1'b0);
    chk("sink", link.wakeDevSink, 1'b1);
    hwr(H_PIN_CTRL, 8'h03);
    wait_rn(1'b1);
    chk("sink", link.wakeDevSink, 1'b0);
    chk("pullUp", link.wakeDevPullUp, 1'b0);
    dwr(PWR_MODE_ADDR, LOW_POWER_CMD);
    rdchk(PWR_MODE_ADDR, 8'h02);
    dwr(HIB_CMD_ADDR, 8'h03);
    settle(2);
    chk("regEn", regEn, 4'h3);
    hwr(H_PIN_CTRL, 8'h07);
    wait_rn(1'b1);
    hwr(H_PIN_CTRL, 8'h01);
    settle(24);
    chk("clkEn", clkEn, 1'b0);
    tally_and_finish();
  end
endmodule // tb_power_saving_mode_control
